// [rtl/eic_top.sv]
// Purpose: central interrupt control and eight external channels
// Assumes: cpu sequencer pulses its commands for one cycle
// Notes: requests are re-arbitrated once per sample period
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - central bit 7 enables the multifunction timer
// - top-level pending set on trigger, cleared on ack, software may set
// - select 1 needs enable and pending; select 0 needs not-maskable
// - enable cleared on non-top ack, set on non-top iret and ei, cleared on di
// - three-bit current level, arbitration mode, nested hardware rewrites level
// - per-channel edge select, 0 falling, 1 rising
// - channel pending set on edge, cleared on ack, software may set
// - channel requests need mask, pending and global enable
// - channel priority is pair bits plus channel parity
// - vector upper nibble from software, lower from channel
// - non-maskable input edge chosen by top-level edge bit
// - top-level source watchdog end-of-count or non-maskable pin
// - channel a0 source watchdog end-of-count or pin
// - wait pin honoured only when external wait enabled
// - not-maskable bit set by software, cleared only by reset
// - nested mode hold bit set when level interrupted, cleared on return
// - wake line unit may replace channel d1 source
// - each wake line has mode, edge polarity and mask
// - requests sampled every five cycles, ack one more cycle
module eic_top (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // interrupt sources
    input wire logic [7:0] ext_pin,
    input wire logic nmi_pin,
    input wire logic watchdog_eoc,
    input wire logic [15:0] wake_line,
    input wire logic wait_input_pin_n,
    // cpu interrupt sequencer
    input wire eic_pkg::eic_cpu_cmd_type cpu_cmd,
    output logic top_request,
    output eic_pkg::eic_ext_req_type ext_out,
    // side outputs
    output logic global_counter_enable,
    output logic memory_wait,
    output logic wake_up
);

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    function automatic logic hit(input logic prev, input logic cur,
                                 input logic rise);
        hit = rise ? (!prev && cur) : (prev && !cur);
    endfunction : hit

    function automatic logic [2:0] chan_prio(input logic [7:0] p,
                                             input logic [2:0] c);
        logic [7:0] sh;
        sh = p >> {c[2:1], 1'b0};
        chan_prio = {sh[1:0], c[0]};
    endfunction : chan_prio

    function automatic logic [15:0] put_byte(input logic [15:0] v,
                                             input logic h,
                                             input logic [7:0] b);
        put_byte = h ? {b, v[7:0]} : {v[15:8], b};
    endfunction : put_byte

    function automatic logic [7:0] get_byte(input logic [15:0] v,
                                            input logic h);
        get_byte = h ? v[15:8] : v[7:0];
    endfunction : get_byte

    eic_pkg::eic_state_type s;
    eic_pkg::eic_state_type n;
    logic tick;
    logic [7:0] chan_src;
    logic [7:0] chan_evt;
    logic [15:0] wake_evt;
    logic wake_any;
    logic tl_src;
    logic tl_evt;
    logic [7:0] base;
    logic hi;
    logic win_ok;
    logic [2:0] win_chan;
    logic [2:0] win_prio;
    logic [2:0] cand_p;
    logic held;
    logic [2:0] held_lvl;

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb begin
        n = s;
        base = {reg_addr[7:1], 1'b0};
        hi = reg_addr[0];
        tick = (s.div == eic_pkg::SAMPLE_LAST);
        n.div = tick ? 3'h0 : s.div + 3'h1;
        // synchronisers
        n.pin_s1 = ext_pin;
        n.pin_s2 = s.pin_s1;
        n.nmi_s1 = nmi_pin;
        n.nmi_s2 = s.nmi_s1;
        n.wait_s1 = wait_input_pin_n;
        n.wait_s2 = s.wait_s1;
        n.wk_s1 = wake_line;
        n.wk_s2 = s.wk_s1;
        n.wk_prev = s.wk_s2;
        // sources and edges
        wake_evt = '0;
        for (int i = 0; i < 16; i++) begin
            wake_evt[i] = hit(s.wk_prev[i], s.wk_s2[i], s.wedge[i]);
        end
        wake_any = |(s.wpend & s.wmask);
        n.wakeup = |(s.wpend & s.wmask & s.wmode);
        chan_src = s.pin_s2;
        if (!s.vect[eic_pkg::VEC_A0S]) begin
            chan_src[0] = watchdog_eoc;
        end
        if (s.d1_wake) begin
            chan_src[7] = wake_any;
        end
        chan_evt = '0;
        for (int i = 0; i < 8; i++) begin
            chan_evt[i] = hit(s.src_prev[i], chan_src[i], s.edge_sel[i]);
        end
        n.src_prev = chan_src;
        tl_src = s.vect[eic_pkg::VEC_TOP_LEVEL_INPUT_SELECT] ? s.nmi_s2 : watchdog_eoc;
        // end-of-count is a rising pulse; only the pin has a choice
        tl_evt = s.vect[eic_pkg::VEC_TOP_LEVEL_INPUT_SELECT]
            ? hit(s.tl_prev, tl_src, s.vect[eic_pkg::VEC_TOP_LEVEL_EDGE_SELECT])
            : (!s.tl_prev && tl_src);
        n.tl_prev = tl_src;
        n.mwait = s.vect[eic_pkg::VEC_EXTERNAL_WAIT_ENABLE] && !s.wait_s2;
        // arbitration over sampled state
        win_ok = 1'b0;
        win_chan = 3'h0;
        win_prio = eic_pkg::LOWEST_LEVEL;
        cand_p = 3'h0;
        for (int i = 0; i < 8; i++) begin
            cand_p = chan_prio(s.prio, 3'(i));
            if (s.pend[i] && s.mask[i] && s.central_interrupt_control[eic_pkg::CIC_IEN] &&
                cand_p < s.central_interrupt_control[2:0] &&
                (!win_ok || cand_p < win_prio)) begin
                win_ok = 1'b1;
                win_chan = 3'(i);
                win_prio = cand_p;
            end
        end
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                eic_pkg::OFS_CENTRAL: n.central_interrupt_control = reg_wdata;
                eic_pkg::OFS_EDGE: n.edge_sel = reg_wdata;
                eic_pkg::OFS_PEND: n.pend = reg_wdata;
                eic_pkg::OFS_MASK: n.mask = reg_wdata;
                eic_pkg::OFS_PRIO: n.prio = reg_wdata;
                eic_pkg::OFS_VECTOR: n.vect = reg_wdata;
                // hold bits belong to hardware; software only sets top_level_not_maskable
                eic_pkg::OFS_NEST: n.nest[7] = s.nest[7] | reg_wdata[7];
                eic_pkg::OFS_WAKE_CTRL: n.d1_wake = reg_wdata[0];
                default: begin
                    case (base)
                        eic_pkg::OFS_WAKE_MASK:
                            n.wmask = put_byte(s.wmask, hi, reg_wdata);
                        eic_pkg::OFS_WAKE_EDGE:
                            n.wedge = put_byte(s.wedge, hi, reg_wdata);
                        eic_pkg::OFS_WAKE_MODE:
                            n.wmode = put_byte(s.wmode, hi, reg_wdata);
                        eic_pkg::OFS_WAKE_PEND:
                            n.wpend = put_byte(s.wpend, hi, reg_wdata);
                        default: n.rdata = n.rdata;
                    endcase
                end
            endcase
        end
        // cpu sequencer commands
        if (cpu_cmd.ei) begin
            n.central_interrupt_control[eic_pkg::CIC_IEN] = 1'b1;
        end
        if (cpu_cmd.di) begin
            n.central_interrupt_control[eic_pkg::CIC_IEN] = 1'b0;
        end
        if (cpu_cmd.iack && cpu_cmd.iack_top) begin
            n.central_interrupt_control[eic_pkg::CIC_TOP_LEVEL_PENDING] = 1'b0;
            n.top_req = 1'b0;
        end else if (cpu_cmd.iack) begin
            n.pend[s.ext.chan] = 1'b0;
            n.central_interrupt_control[eic_pkg::CIC_IEN] = 1'b0;
            n.ext.req = 1'b0;
            if (s.central_interrupt_control[eic_pkg::CIC_IAM]) begin
                if (s.central_interrupt_control[2:0] != eic_pkg::LOWEST_LEVEL) begin
                    n.nest[s.central_interrupt_control[2:0]] = 1'b1;
                end
                n.central_interrupt_control[2:0] = s.ext.prio;
            end
        end
        held = 1'b0;
        held_lvl = eic_pkg::LOWEST_LEVEL;
        for (int i = 6; i >= 0; i--) begin
            if (s.nest[i]) begin
                held = 1'b1;
                held_lvl = 3'(i);
            end
        end
        if (cpu_cmd.iret && !cpu_cmd.iret_top) begin
            n.central_interrupt_control[eic_pkg::CIC_IEN] = 1'b1;
            if (s.central_interrupt_control[eic_pkg::CIC_IAM]) begin
                n.central_interrupt_control[2:0] = held_lvl;
                if (held) begin
                    n.nest[held_lvl] = 1'b0;
                end
            end
        end
        // hardware events last: a set beats a same-cycle clear
        if (tl_evt) begin
            n.central_interrupt_control[eic_pkg::CIC_TOP_LEVEL_PENDING] = 1'b1;
        end
        n.pend = n.pend | chan_evt;
        n.wpend = n.wpend | wake_evt;
        // one sample per period; an ack in the tick cycle skips it
        if (tick && !cpu_cmd.iack) begin
            n.top_req = s.central_interrupt_control[eic_pkg::CIC_TOP_LEVEL_PENDING] &&
                (s.nest[eic_pkg::NEST_TOP_LEVEL_NOT_MASKABLE] ||
                 (s.central_interrupt_control[eic_pkg::CIC_TLI] &&
                  s.central_interrupt_control[eic_pkg::CIC_IEN]));
            n.ext.req = win_ok;
            n.ext.chan = win_chan;
            n.ext.prio = win_prio;
            n.ext.vector = {s.vect[7:4], win_chan, 1'b0};
        end
        // register reads, data valid one cycle later only
        n.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                eic_pkg::OFS_CENTRAL: n.rdata = s.central_interrupt_control;
                eic_pkg::OFS_EDGE: n.rdata = s.edge_sel;
                eic_pkg::OFS_PEND: n.rdata = s.pend;
                eic_pkg::OFS_MASK: n.rdata = s.mask;
                eic_pkg::OFS_PRIO: n.rdata = s.prio;
                eic_pkg::OFS_VECTOR: n.rdata = s.vect;
                eic_pkg::OFS_NEST: n.rdata = s.nest;
                eic_pkg::OFS_WAKE_CTRL: n.rdata = {7'h00, s.d1_wake};
                default: begin
                    case (base)
                        eic_pkg::OFS_WAKE_MASK:
                            n.rdata = get_byte(s.wmask, hi);
                        eic_pkg::OFS_WAKE_EDGE:
                            n.rdata = get_byte(s.wedge, hi);
                        eic_pkg::OFS_WAKE_MODE:
                            n.rdata = get_byte(s.wmode, hi);
                        eic_pkg::OFS_WAKE_PEND:
                            n.rdata = get_byte(s.wpend, hi);
                        default: n.rdata = 8'h00;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= eic_pkg::RESET_STATE;
        end else begin
            s <= n;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign reg_rdata = s.rdata;
    assign top_request = s.top_req;
    assign ext_out = s.ext;
    assign global_counter_enable = s.central_interrupt_control[eic_pkg::CIC_GLOBAL_COUNTER_ENABLE];
    assign memory_wait = s.mwait;
    assign wake_up = s.wakeup;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_GLOBAL_COUNTER_ENABLE: assert property (
        reg_wr && reg_addr == eic_pkg::OFS_CENTRAL
        |=> global_counter_enable == $past(reg_wdata[7]))
        else $error("timer enable does not follow write");

    AST_TOP_LEVEL_PENDING_ACK: assert property (
        cpu_cmd.iack && cpu_cmd.iack_top && !tl_evt && !reg_wr
        |=> !s.central_interrupt_control[eic_pkg::CIC_TOP_LEVEL_PENDING] && !top_request)
        else $error("top pending not cleared by ack");

    AST_TOP_REQ: assert property (
        tick && !cpu_cmd.iack
        |=> top_request == ($past(s.central_interrupt_control[6]) && ($past(s.nest[7]) ||
            ($past(s.central_interrupt_control[5]) && $past(s.central_interrupt_control[4])))))
        else $error("top request gating wrong");

    AST_IEN_ACK: assert property (
        cpu_cmd.iack && !cpu_cmd.iack_top && !cpu_cmd.ei && !reg_wr
        |=> !s.central_interrupt_control[eic_pkg::CIC_IEN])
        else $error("enable not cleared on channel ack");

    AST_CPL_NEST: assert property (
        cpu_cmd.iack && !cpu_cmd.iack_top && s.central_interrupt_control[3] && !reg_wr
        |=> s.central_interrupt_control[2:0] == $past(ext_out.prio))
        else $error("nested level not taken from ack");

    AST_HOLD: assert property (
        cpu_cmd.iack && !cpu_cmd.iack_top && s.central_interrupt_control[3] &&
        s.central_interrupt_control[2:0] != eic_pkg::LOWEST_LEVEL
        |=> s.nest[$past(s.central_interrupt_control[2:0])])
        else $error("hold bit not set on nesting");

    AST_EXT_REQ: assert property (
        $rose(ext_out.req)
        |-> $past(s.central_interrupt_control[4]) && ($past(s.pend) & $past(s.mask)) != 8'h00)
        else $error("channel request without enable");

    AST_PRIO: assert property (
        ext_out.req |-> ext_out.prio[0] == ext_out.chan[0])
        else $error("priority parity mismatch");

    AST_VEC: assert property (
        $rose(ext_out.req) |-> ext_out.vector[7:4] == $past(s.vect[7:4])
        && ext_out.vector[3:1] == ext_out.chan)
        else $error("vector not formed from nibble and channel");

    AST_WAIT: assert property (
        !s.vect[0] ##1 !s.vect[0] |-> !memory_wait)
        else $error("wait honoured while disabled");

    AST_SAMPLE: assert property (
        $rose(ext_out.req) |-> $past(tick) ##0 !tick [*4])
        else $error("request outside sample point");

endmodule : eic_top

`default_nettype wire

// [rtl/eic_pkg.sv]
// Purpose: shared constants and types of the external interrupt control unit
// Assumes: byte-wide register port, one 100 MHz clock
// Notes: wake line registers are 16 bits split into low and high bytes
package eic_pkg;

    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_CENTRAL = 8'hE6;
    localparam logic [7:0] OFS_EDGE = 8'hF2;
    localparam logic [7:0] OFS_PEND = 8'hF3;
    localparam logic [7:0] OFS_MASK = 8'hF4;
    localparam logic [7:0] OFS_PRIO = 8'hF5;
    localparam logic [7:0] OFS_VECTOR = 8'hF6;
    localparam logic [7:0] OFS_NEST = 8'hF7;
    localparam logic [7:0] OFS_WAKE_MASK = 8'hE8;
    localparam logic [7:0] OFS_WAKE_EDGE = 8'hEA;
    localparam logic [7:0] OFS_WAKE_MODE = 8'hEC;
    localparam logic [7:0] OFS_WAKE_PEND = 8'hEE;
    localparam logic [7:0] OFS_WAKE_CTRL = 8'hF0;

    // -------------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------------
    localparam int CIC_GLOBAL_COUNTER_ENABLE = 7;
    localparam int CIC_TOP_LEVEL_PENDING = 6;
    localparam int CIC_TLI = 5;
    localparam int CIC_IEN = 4;
    localparam int CIC_IAM = 3;
    localparam int VEC_TOP_LEVEL_EDGE_SELECT = 3;
    localparam int VEC_TOP_LEVEL_INPUT_SELECT = 2;
    localparam int VEC_A0S = 1;
    localparam int VEC_EXTERNAL_WAIT_ENABLE = 0;
    localparam int NEST_TOP_LEVEL_NOT_MASKABLE = 7;
    localparam logic [7:0] RST_CENTRAL = 8'h87;
    localparam logic [7:0] RST_PRIO = 8'hFF;
    localparam logic [7:0] RST_VECTOR = 8'h06;
    localparam logic [2:0] LOWEST_LEVEL = 3'h7;
    localparam logic [2:0] SAMPLE_CYCLES = 3'h5;
    localparam logic [2:0] SAMPLE_LAST = SAMPLE_CYCLES - 3'h1;

    // -------------------------------------------------------------------
    // carriers and state
    // -------------------------------------------------------------------
    typedef struct packed {
        logic iack;
        logic iack_top;
        logic iret;
        logic iret_top;
        logic ei;
        logic di;
    } eic_cpu_cmd_type;

    typedef struct packed {
        logic req;
        logic [2:0] chan;
        logic [2:0] prio;
        logic [7:0] vector;
    } eic_ext_req_type;

    typedef struct packed {
        logic [7:0] central_interrupt_control, edge_sel, pend, mask, prio, vect, nest;
        logic [15:0] wmask, wedge, wmode, wpend;
        logic d1_wake;
        logic [7:0] pin_s1, pin_s2, src_prev;
        logic nmi_s1, nmi_s2, wait_s1, wait_s2, tl_prev;
        logic [15:0] wk_s1, wk_s2, wk_prev;
        logic [2:0] div;
        logic top_req;
        eic_ext_req_type ext;
        logic mwait, wakeup;
        logic [7:0] rdata;
    } eic_state_type;

    localparam eic_state_type RESET_STATE = '{
        central_interrupt_control: RST_CENTRAL, prio: RST_PRIO, vect: RST_VECTOR,
        wait_s1: 1'b1, wait_s2: 1'b1, default: '0};

endpackage : eic_pkg

// [dv/eic_cpu_model.sv]
// Purpose: behavioural cpu interrupt sequencer facing the control unit
// Assumes: any standing request is acknowledged after a set delay while ack_en is high
// Notes: commands are one-cycle pulses; enable wins over an acknowledge
`timescale 1ns/1ps
`default_nettype none
module eic_cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bench control
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    input wire logic ei_req,
    input wire logic iret_req,
    // control unit side
    input wire logic top_request,
    input wire eic_pkg::eic_ext_req_type ext_out,
    output var eic_pkg::eic_cpu_cmd_type cpu_cmd
);
    // -------------------------------------------------------------------
    // sequencer
    // -------------------------------------------------------------------
    logic [3:0] wait_cnt;
    always @(posedge clk) begin : seq
        eic_pkg::eic_cpu_cmd_type c;
        c = '0;
        if (!rstn) begin
            wait_cnt <= 4'h0;
        end else if (ei_req) begin
            c.ei = 1'b1;
        end else if (iret_req) begin
            c.iret = 1'b1;
        end else if (ack_en && (top_request || ext_out.req) &&
                     !cpu_cmd.iack) begin
            // slow answers model an instruction that cannot be aborted
            if (wait_cnt == ack_delay) begin
                c.iack = 1'b1;
                c.iack_top = top_request;
                wait_cnt <= 4'h0;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
        cpu_cmd <= c;
    end
endmodule : eic_cpu_model
`default_nettype wire

// [dv/eic_top_tb.sv]
// Purpose: self-checking bench of the external interrupt control unit
// Assumes: cpu model acks standing requests while enabled
// Notes: nested mode and wake lines get one scenario each
`timescale 1ns/1ps
`default_nettype none
module eic_top_tb;
    // -------------------------------------------------------------------
    // signals and instances
    // -------------------------------------------------------------------
    logic clk, rstn, reg_wr, reg_rd, nmi_pin, watchdog_eoc, wait_n, rd_d;
    logic ack_en, ei_req, iret_req, top_request, memory_wait, wake_up, gce;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ext_pin;
    logic [3:0] ack_delay, nib;
    logic [31:0] seed;
    logic [15:0] wake;
    eic_pkg::eic_cpu_cmd_type cpu_cmd;
    eic_pkg::eic_ext_req_type ext_out;
    logic [15:0] rd_q[$];
    eic_pkg::eic_ext_req_type req_q[$];
    int fail_count, check_count, ack_n, cycles;

    eic_top DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_pin(ext_pin), .nmi_pin(nmi_pin),
        .watchdog_eoc(watchdog_eoc), .wake_line(wake),
        .wait_input_pin_n(wait_n), .cpu_cmd(cpu_cmd),
        .top_request(top_request), .ext_out(ext_out),
        .global_counter_enable(gce), .memory_wait(memory_wait),
        .wake_up(wake_up));
    eic_cpu_model PARTNER (.clk(clk), .rstn(rstn), .ack_en(ack_en),
        .ack_delay(ack_delay), .ei_req(ei_req), .iret_req(iret_req),
        .top_request(top_request),
        .ext_out(ext_out), .cpu_cmd(cpu_cmd));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // -------------------------------------------------------------------
    // checking and bus tasks
    // -------------------------------------------------------------------
    task automatic close_out();
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input logic [7:0] msk);
        check_count++;
        if ((got & msk) !== (exp & msk)) begin
            fail_count++;
            $display("Error at %0t: read %h want %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: flag %b want %b", $time, got, exp);
        end
    endtask : chk1

    task automatic chk_req(input eic_pkg::eic_ext_req_type got,
                           input eic_pkg::eic_ext_req_type exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: request %h want %h", $time, got, exp);
        end
    endtask : chk_req

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        rd_q.push_back({m, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic enable_irq();
        ei_req <= 1'b1;
        idle(1);
        ei_req <= 1'b0;
    endtask : enable_irq

    task automatic wait_ack(input int n0);
        idle(1);
        for (int i = 0; i < 60 && ack_n == n0; i++) @(posedge clk);
        chk1(ack_n != n0, 1'b1);
    endtask : wait_ack

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin : monitor
        logic [15:0] e;
        rd_d <= reg_rd;
        if (rd_d) begin
            e = rd_q.pop_front();
            chk8(reg_rdata, e[7:0], e[15:8]);
        end
        if (rstn && cpu_cmd.iack && cpu_cmd.iack_top) begin
            chk1(top_request, 1'b1);
            ack_n++;
        end else if (rstn && cpu_cmd.iack) begin
            chk_req(ext_out, req_q.pop_front());
            ack_n++;
        end
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            close_out();
        end
    end

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        logic [7:0] a, d;
        logic [1:0] p2;
        int n;
        eic_pkg::eic_ext_req_type x;
        seed = 32'h61743761;
        rstn = 1'b0;
        {reg_wr, reg_rd, nmi_pin, watchdog_eoc, ei_req, iret_req, rd_d} = '0;
        wake = 16'h0000;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ext_pin = 8'h33;
        wait_n = 1'b1;
        ack_en = 1'b1;
        ack_delay = 4'h0;
        {fail_count, check_count, ack_n, cycles} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        idle(2);
        chk1(gce, 1'b1);
        rd(eic_pkg::OFS_CENTRAL, 8'h87, 8'hFF);
        rd(eic_pkg::OFS_EDGE, 8'h00, 8'hFF);
        rd(eic_pkg::OFS_PEND, 8'h00, 8'hFF);
        rd(eic_pkg::OFS_MASK, 8'h00, 8'hFF);
        rd(eic_pkg::OFS_PRIO, 8'hFF, 8'hFF);
        rd(eic_pkg::OFS_VECTOR, 8'h06, 8'h0F);
        rd(eic_pkg::OFS_NEST, 8'h00, 8'hFF);
        rd(8'h10, 8'h00, 8'hFF);
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? eic_pkg::OFS_EDGE :
                (i == 1) ? eic_pkg::OFS_MASK : eic_pkg::OFS_PRIO;
            d = 8'(rnd());
            wr(a, d);
            rd(a, d, 8'hFF);
        end
        nib = 4'(rnd());
        wr(eic_pkg::OFS_EDGE, 8'hCC);
        wr(eic_pkg::OFS_MASK, 8'h00);
        wr(eic_pkg::OFS_VECTOR, {nib, 4'h6});
        for (int c = 0; c < 8; c++) begin
            // priority 7 never beats the idle level, so keep odd ones at 5
            p2 = 2'(rnd());
            if (c[0] && p2 == 2'h3) p2 = 2'h2;
            ack_delay <= 4'(rnd());
            wr(eic_pkg::OFS_PRIO, {4{p2}});
            enable_irq();
            ext_pin[c] <= ~ext_pin[c];
            idle(8);
            chk1(ext_out.req, 1'b0);
            rd(eic_pkg::OFS_PEND, 8'h01 << c, 8'hFF);
            ext_pin[c] <= ~ext_pin[c];
            x.req = 1'b1;
            x.chan = 3'(c);
            x.prio = {p2, c[0]};
            x.vector = {nib, 3'(c), 1'b0};
            req_q.push_back(x);
            n = ack_n;
            wr(eic_pkg::OFS_MASK, 8'h01 << c);
            wait_ack(n);
            rd(eic_pkg::OFS_PEND, 8'h00, 8'hFF);
            rd(eic_pkg::OFS_CENTRAL, 8'h87, 8'hFF);
        end
        ack_delay <= 4'h3;
        wr(eic_pkg::OFS_VECTOR, {nib, 4'hE});
        nmi_pin <= 1'b1;
        idle(8);
        chk1(top_request, 1'b0);
        rd(eic_pkg::OFS_CENTRAL, 8'hC7, 8'hFF);
        nmi_pin <= 1'b0;
        n = ack_n;
        wr(eic_pkg::OFS_NEST, 8'h80);
        wait_ack(n);
        rd(eic_pkg::OFS_CENTRAL, 8'h87, 8'hFF);
        wr(eic_pkg::OFS_NEST, 8'h00);
        rd(eic_pkg::OFS_NEST, 8'h80, 8'hFF);
        // nested mode: level 5 interrupted by channel d1 at level 1
        wr(eic_pkg::OFS_PRIO, 8'h00);
        wr(eic_pkg::OFS_CENTRAL, 8'h8D);
        wr(eic_pkg::OFS_PEND, 8'h80);
        x.req = 1'b1;
        x.chan = 3'h7;
        x.prio = 3'h1;
        x.vector = {nib, 3'h7, 1'b0};
        req_q.push_back(x);
        n = ack_n;
        enable_irq();
        wait_ack(n);
        rd(eic_pkg::OFS_CENTRAL, 8'h89, 8'hFF);
        rd(eic_pkg::OFS_NEST, 8'hA0, 8'hFF);
        iret_req <= 1'b1;
        idle(1);
        iret_req <= 1'b0;
        idle(1);
        rd(eic_pkg::OFS_CENTRAL, 8'h9D, 8'hFF);
        rd(eic_pkg::OFS_NEST, 8'h80, 8'hFF);
        // nothing pending, so the enable may be rewritten here
        wr(eic_pkg::OFS_CENTRAL, 8'h87);
        ack_en <= 1'b0;
        // rising select on a0 so the source switch makes no edge
        wr(eic_pkg::OFS_EDGE, 8'hCD);
        wr(eic_pkg::OFS_VECTOR, {nib, 4'h8});
        // let the edge detectors settle on the new sources first
        idle(1);
        watchdog_eoc <= 1'b1;
        idle(1);
        watchdog_eoc <= 1'b0;
        idle(2);
        rd(eic_pkg::OFS_PEND, 8'h01, 8'hFF);
        rd(eic_pkg::OFS_CENTRAL, 8'hC7, 8'hFF);
        wr(eic_pkg::OFS_PEND, 8'h00);
        wr(eic_pkg::OFS_CENTRAL, 8'h87);
        rd(eic_pkg::OFS_PEND, 8'h00, 8'hFF);
        rd(eic_pkg::OFS_CENTRAL, 8'h87, 8'hFF);
        wait_n <= 1'b0;
        wr(eic_pkg::OFS_VECTOR, {nib, 4'h9});
        idle(5);
        chk1(memory_wait, 1'b1);
        wr(eic_pkg::OFS_VECTOR, {nib, 4'h8});
        idle(3);
        chk1(memory_wait, 1'b0);
        wr(eic_pkg::OFS_CENTRAL, 8'h07);
        idle(2);
        chk1(gce, 1'b0);
        // wake line 0 in wake mode, also routed onto channel d1
        wr(eic_pkg::OFS_WAKE_CTRL, 8'h01);
        wr(eic_pkg::OFS_WAKE_MASK, 8'h01);
        wr(eic_pkg::OFS_WAKE_EDGE, 8'h01);
        wr(eic_pkg::OFS_WAKE_MODE, 8'h01);
        wake[0] <= 1'b1;
        idle(6);
        chk1(wake_up, 1'b1);
        rd(eic_pkg::OFS_WAKE_PEND, 8'h01, 8'hFF);
        rd(eic_pkg::OFS_PEND, 8'h80, 8'hFF);
        idle(3);
        close_out();
    end
endmodule : eic_top_tb
`default_nettype wire
